// ===== blink_timer.sv
// Flash time base: half-period tick and running phase
`timescale 1ns/10ps
module blink_timer #(
    parameter int HALF_CYCLES = enc_led_pkg::FLASH_HALF_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Time base
    output logic tick,
    output logic phase
);
    logic [31:0] cnt_r;
    logic phase_r;
    wire last = (cnt_r == 32'(HALF_CYCLES - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 32'h0;
            phase_r <= 1'b0;
        end else if (last) begin
            cnt_r <= 32'h0;
            phase_r <= ~phase_r;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end

    assign tick = last;
    assign phase = phase_r;
endmodule

// ===== enc_led_pkg.sv
// Shared constants for the encoder position and module indicator block
package enc_led_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_POSITION = 8'h04;
    localparam logic [7:0] OFF_CAPTURED = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_LED_STATE = 8'h14;
    // Control fields
    localparam int CTL_RES_LSB = 0;
    localparam int CTL_MODE_LSB = 2;
    localparam int CTL_ACT_BIT = 4;
    localparam logic [4:0] CONTROL_RESET = 5'h12;
    // Resolution codes and edge masks
    localparam logic [1:0] RES_1024 = 2'h0;
    localparam logic [1:0] RES_2048 = 2'h1;
    localparam logic [1:0] RES_4096 = 2'h2;
    localparam logic [1:0] MASK_1024 = 2'h3;
    localparam logic [1:0] MASK_2048 = 2'h1;
    localparam logic [1:0] MASK_4096 = 2'h0;
    // Capture input modes
    localparam logic [1:0] CAP_OFF = 2'h0;
    localparam logic [1:0] CAP_INDEXER = 2'h1;
    localparam logic [1:0] CAP_STOP_JOG = 2'h2;
    // Status bits
    localparam int ST_CAPTURE = 0;
    localparam int ST_FAULT = 1;
    localparam int ST_ABS_ERR = 2;
    localparam int ST_WIDTH = 3;
    // Absolute encoder layout
    localparam int ABS_TURN_BITS = 21;
    localparam int ABS_ANGLE_BITS = 11;
    localparam int POS_BITS = 32;
    // Three red blinks = six half periods
    localparam logic [2:0] ERR_HALVES = 3'h6;
    // Indicator timing
    localparam int CLK_HZ = 40_000_000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;
    // Indicator pattern codes shown in LED_STATE
    typedef enum logic [2:0] {
        PAT_OFF, PAT_OVERTEMP, PAT_COMM_FAIL, PAT_LATCHED_RED,
        PAT_ABS_ERR, PAT_INIT, PAT_WAIT_LINK, PAT_OPERATIONAL
    } pattern_t;
endpackage

// ===== enc_partner.sv
// Encoder model: quadrature channels and absolute multi-turn reading
`timescale 1ns/10ps
module enc_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Quadrature channels
    output logic chan_a,
    output logic chan_b,
    // Absolute reading
    output logic abs_valid,
    output logic [20:0] abs_turns,
    output logic [10:0] abs_angle
);
    logic [1:0] idx_r = 2'h0;
    // Gray order 00,01,11,10 turns forward
    assign chan_a = idx_r[1];
    assign chan_b = idx_r[1] ^ idx_r[0];
    initial begin
        abs_valid = 1'b0;
        abs_turns = 21'h0;
        abs_angle = 11'h0;
    end
    // Power cycle parks the shaft model at phase zero
    always @(negedge reset_n) begin
        idx_r <= 2'h0;
    end
    // Stale reading must not look valid: keep it moving
    always @(negedge clk) begin
        if (!abs_valid) begin
            abs_turns <= ~abs_turns;
            abs_angle <= ~abs_angle;
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic step(input bit up, input int gap);
        @(posedge clk);
        idx_r <= up ? idx_r + 2'h1 : idx_r - 2'h1;
        repeat (gap) @(posedge clk);
    endtask
    task automatic set_abs(input logic [20:0] t, input logic [10:0] a);
        @(posedge clk);
        abs_valid <= 1'b1;
        abs_turns <= t;
        abs_angle <= a;
    endtask
endmodule

// ===== enc_position_led.sv
// Encoder position counter, capture, module indicator and register port
//
// Functional notes
// (R1) Incremental resolution programmable as 1024, 2048 or 4096 counts per turn.
// (R2) Position is held in a 32-bit counter.
// (R3) Incremental position clears to zero at power-up reset.
// (R4) Absolute encoder uses fixed 2048 counts per turn, not programmable.
// (R5) Absolute position joins 21-bit turn count with 11-bit angle.
// (R6) Absolute position is valid after power returns, no homing needed.
// (R7) Inactive-to-active capture input edge latches position and sends it to host.
// (R8) Start-indexer mode latches position on every input transition.
// (R9) Stop-jog mode latches only while jog or registration move runs.
// (R10) Processor link failure alternates red/green, held until power cycle.
// (R11) Flash green while waiting for network physical link.
// (R12) Steady green when drive and network are operational.
// (R13) Setting change with network indicator flashing: flash red, held.
// (R14) Flash write failure otherwise: flash red, held until power cycle.
// (R15) Overtemperature: steady red until power removed.
// (R16) Blink green during power-up initialization.
// (R17) Absolute encoder error at power-up: exactly three red blinks.
// (R18) Count up or down one per decoded edge, wrapping modulo 2^32; code counts every edge at 4096, every 2nd at 2048, every 4th at 1024.
// (R19) Latched faults take priority over initialization and operational patterns.
`timescale 1ns/10ps
module enc_position_led #(
    parameter int FLASH_CYCLES = enc_led_pkg::FLASH_HALF_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // Encoder option and incremental channels
    input wire logic abs_fitted,
    input wire logic chan_a,
    input wire logic chan_b,
    // Absolute encoder
    input wire logic abs_valid,
    input wire logic [enc_led_pkg::ABS_TURN_BITS-1:0] abs_turns,
    input wire logic [enc_led_pkg::ABS_ANGLE_BITS-1:0] abs_angle,
    input wire logic abs_error,
    // Capture input and motion state
    input wire logic capture_in,
    input wire logic move_active,
    // Drive and network condition
    input wire logic init_done,
    input wire logic link_up,
    input wire logic drive_ok,
    input wire logic net_ok,
    input wire logic network_indicator_flashing,
    input wire logic comm_fail,
    input wire logic setting_changed,
    input wire logic flash_write_fail,
    input wire logic overtemp,
    // Host capture output
    output logic [31:0] capture_value,
    output logic capture_valid,
    // Module indicator and interrupt
    output logic module_indicator_red,
    output logic module_indicator_green,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////
    logic [4:0] control_r;
    logic [enc_led_pkg::ST_WIDTH-1:0] status_r;
    logic [enc_led_pkg::ST_WIDTH-1:0] mask_r;
    logic [31:0] pos_r;
    logic [31:0] pos_nxt;
    logic pos_valid_r;
    logic [1:0] fine_r;
    logic cap_prev_r;
    logic [31:0] cap_r;
    logic cap_valid_r;
    logic ot_lat_r;
    logic comm_lat_r;
    logic red_lat_r;
    logic [2:0] err_cnt_r;
    logic err_done_r;
    logic red_r;
    logic green_r;
    logic irq_r;
    logic [31:0] rdata_r;
    logic step;
    logic up;
    logic tick;
    logic phase;
    enc_led_pkg::pattern_t pat;

    quad_decoder u_quad (
        .clk(clk),
        .reset_n(reset_n),
        .chan_a(chan_a),
        .chan_b(chan_b),
        .step(step),
        .up(up)
    );

    blink_timer #(.HALF_CYCLES(FLASH_CYCLES)) u_blink (
        .clk(clk),
        .reset_n(reset_n),
        .tick(tick),
        .phase(phase)
    );

    ////////////////////////////////////////////////////////////////////
    // Control decode
    wire [1:0] res_sel = control_r[enc_led_pkg::CTL_RES_LSB +: 2];
    wire [1:0] cap_mode = control_r[enc_led_pkg::CTL_MODE_LSB +: 2];
    wire act_high = control_r[enc_led_pkg::CTL_ACT_BIT];
    wire [1:0] edge_mask = (res_sel == enc_led_pkg::RES_1024) ? enc_led_pkg::MASK_1024 :
                           (res_sel == enc_led_pkg::RES_2048) ? enc_led_pkg::MASK_2048 :
                           enc_led_pkg::MASK_4096;
    wire sel_control = (addr == enc_led_pkg::OFF_CONTROL);
    wire sel_status = (addr == enc_led_pkg::OFF_STATUS);
    wire sel_mask = (addr == enc_led_pkg::OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////
    // Position counter
    wire [1:0] fine_up = fine_r + 2'h1;
    wire [1:0] fine_dn = fine_r - 2'h1;
    wire inc_pulse = step && up && ((fine_up & edge_mask) == 2'h0); // R1
    wire dec_pulse = step && !up && ((fine_r & edge_mask) == 2'h0); // R1
    wire [31:0] abs_pos = {abs_turns, abs_angle}; // R4 R5

    always_comb begin
        pos_nxt = pos_r;
        if (abs_fitted) begin
            if (abs_valid) begin
                pos_nxt = abs_pos; // R5 R6
            end
        end else if (inc_pulse) begin
            pos_nxt = pos_r + 32'h1; // R18 R2
        end else if (dec_pulse) begin
            pos_nxt = pos_r - 32'h1; // R18
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pos_r <= 32'h0; // R3
            fine_r <= 2'h0;
            pos_valid_r <= 1'b0;
        end else begin
            pos_r <= pos_nxt;
            if (!abs_fitted && step) begin
                fine_r <= up ? fine_up : fine_dn;
            end
            pos_valid_r <= pos_valid_r || !abs_fitted || abs_valid; // R6
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Capture input
    wire cap_active = capture_in ~^ act_high;
    wire cap_rise = cap_active && !cap_prev_r;
    wire cap_any = cap_active != cap_prev_r;
    wire cap_fire = (cap_mode == enc_led_pkg::CAP_INDEXER) ? cap_any : // R8
                    (cap_mode == enc_led_pkg::CAP_STOP_JOG) ? (cap_rise && move_active) : // R9
                    1'b0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cap_prev_r <= 1'b0;
            cap_r <= 32'h0;
            cap_valid_r <= 1'b0;
        end else begin
            cap_prev_r <= cap_active;
            cap_valid_r <= cap_fire; // R7
            if (cap_fire) begin
                cap_r <= pos_r; // R7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault latches, only a power cycle clears them
    wire red_set = (setting_changed && network_indicator_flashing) // R13
                   || (flash_write_fail && !network_indicator_flashing); // R14
    wire err_start = abs_fitted && abs_error && !init_done && !err_done_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ot_lat_r <= 1'b0;
            comm_lat_r <= 1'b0;
            red_lat_r <= 1'b0;
            err_cnt_r <= 3'h0;
            err_done_r <= 1'b0;
        end else begin
            ot_lat_r <= ot_lat_r || overtemp; // R15
            comm_lat_r <= comm_lat_r || comm_fail; // R10
            red_lat_r <= red_lat_r || red_set; // R13 R14
            if (err_start) begin
                err_cnt_r <= enc_led_pkg::ERR_HALVES; // R17
                err_done_r <= 1'b1;
            end else if (tick && err_cnt_r != 3'h0) begin
                err_cnt_r <= err_cnt_r - 3'h1; // R17
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Indicator pattern priority
    assign pat = ot_lat_r ? enc_led_pkg::PAT_OVERTEMP : // R19
                 comm_lat_r ? enc_led_pkg::PAT_COMM_FAIL :
                 red_lat_r ? enc_led_pkg::PAT_LATCHED_RED :
                 (err_cnt_r != 3'h0) ? enc_led_pkg::PAT_ABS_ERR :
                 !init_done ? enc_led_pkg::PAT_INIT :
                 !link_up ? enc_led_pkg::PAT_WAIT_LINK :
                 (drive_ok && net_ok) ? enc_led_pkg::PAT_OPERATIONAL :
                 enc_led_pkg::PAT_OFF;

    logic red_nxt;
    logic green_nxt;
    always_comb begin
        red_nxt = 1'b0;
        green_nxt = 1'b0;
        case (pat)
            enc_led_pkg::PAT_OVERTEMP: begin
                red_nxt = 1'b1; // R15
            end
            enc_led_pkg::PAT_COMM_FAIL: begin
                red_nxt = phase; // R10
                green_nxt = ~phase;
            end
            enc_led_pkg::PAT_LATCHED_RED: begin
                red_nxt = phase; // R13 R14
            end
            enc_led_pkg::PAT_ABS_ERR: begin
                red_nxt = err_cnt_r[0]; // R17
            end
            enc_led_pkg::PAT_INIT: begin
                green_nxt = phase; // R16
            end
            enc_led_pkg::PAT_WAIT_LINK: begin
                green_nxt = phase; // R11
            end
            enc_led_pkg::PAT_OPERATIONAL: begin
                green_nxt = 1'b1; // R12
            end
            default: begin
                red_nxt = 1'b0;
                green_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            red_r <= 1'b0;
            green_r <= 1'b0;
        end else begin
            red_r <= red_nxt;
            green_r <= green_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers and interrupt
    wire [enc_led_pkg::ST_WIDTH-1:0] st_events;
    assign st_events[enc_led_pkg::ST_CAPTURE] = cap_fire;
    assign st_events[enc_led_pkg::ST_FAULT] = overtemp || comm_fail || red_set;
    assign st_events[enc_led_pkg::ST_ABS_ERR] = err_start;
    wire [enc_led_pkg::ST_WIDTH-1:0] st_clear =
        (wr_en && sel_status) ? wdata[enc_led_pkg::ST_WIDTH-1:0] : '0;
    // Set wins over a clear in the same cycle
    wire [enc_led_pkg::ST_WIDTH-1:0] status_nxt = (status_r & ~st_clear) | st_events;

    wire [31:0] rd_mux =
        (addr == enc_led_pkg::OFF_CONTROL) ? {27'h0, control_r} :
        (addr == enc_led_pkg::OFF_POSITION) ? pos_r :
        (addr == enc_led_pkg::OFF_CAPTURED) ? cap_r :
        (addr == enc_led_pkg::OFF_STATUS) ? {29'h0, status_r} :
        (addr == enc_led_pkg::OFF_IRQ_MASK) ? {29'h0, mask_r} :
        (addr == enc_led_pkg::OFF_LED_STATE) ? {27'h0, pos_valid_r, 1'b0, pat} :
        32'h0;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_r <= enc_led_pkg::CONTROL_RESET;
            status_r <= '0;
            mask_r <= '0;
            irq_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            if (wr_en && sel_control) begin
                control_r <= wdata[4:0]; // R1
            end
            if (wr_en && sel_mask) begin
                mask_r <= wdata[enc_led_pkg::ST_WIDTH-1:0];
            end
            status_r <= status_nxt;
            irq_r <= |(status_nxt & mask_r);
            rdata_r <= rd_en ? rd_mux : 32'h0;
        end
    end

    assign rdata = rdata_r;
    assign capture_value = cap_r;
    assign capture_valid = cap_valid_r;
    assign module_indicator_red = red_r;
    assign module_indicator_green = green_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_full_res_step;
        !abs_fitted && res_sel == enc_led_pkg::RES_4096 && step && up
            |=> pos_r == $past(pos_r) + 32'h1;
    endproperty
    a_full_res_step: assert property (p_full_res_step) else $error("missed count"); // R18

    property p_low_res_hold;
        !abs_fitted && res_sel == enc_led_pkg::RES_1024 && step && up && fine_r == 2'h0
            |=> pos_r == $past(pos_r);
    endproperty
    a_low_res_hold: assert property (p_low_res_hold) else $error("bad scaling"); // R1

    property p_abs_load;
        abs_fitted && abs_valid |=> pos_r == $past(abs_pos) && pos_valid_r;
    endproperty
    a_abs_load: assert property (p_abs_load) else $error("abs not loaded"); // R5

    property p_indexer_capture;
        cap_mode == enc_led_pkg::CAP_INDEXER && cap_any |=> capture_valid
            && capture_value == $past(pos_r) ##1 capture_valid == $past(cap_fire);
    endproperty
    a_indexer_capture: assert property (p_indexer_capture) else $error("no capture"); // R8

    property p_jog_idle;
        cap_mode == enc_led_pkg::CAP_STOP_JOG && !move_active |=> !capture_valid;
    endproperty
    a_jog_idle: assert property (p_jog_idle) else $error("stray capture"); // R9

    property p_overtemp;
        overtemp |-> ##2 (module_indicator_red && !module_indicator_green) [*8];
    endproperty
    a_overtemp: assert property (p_overtemp) else $error("overtemp not red"); // R15

    property p_comm_alt;
        comm_fail && !overtemp && !ot_lat_r
            |-> ##2 (module_indicator_red != module_indicator_green) || ot_lat_r;
    endproperty
    a_comm_alt: assert property (p_comm_alt) else $error("no alternation"); // R10

    property p_operational;
        pat == enc_led_pkg::PAT_OPERATIONAL |=> module_indicator_green && !module_indicator_red;
    endproperty
    a_operational: assert property (p_operational) else $error("not steady green"); // R12

    property p_red_latch;
        red_lat_r && !comm_lat_r |=> red_lat_r && !module_indicator_green;
    endproperty
    a_red_latch: assert property (p_red_latch) else $error("fault lost"); // R13

    property p_err_blinks;
        err_start |=> err_cnt_r == enc_led_pkg::ERR_HALVES;
    endproperty
    a_err_blinks: assert property (p_err_blinks) else $error("blink count"); // R17

    c_capture: cover property (capture_valid);
    c_wrap: cover property (pos_r == 32'hFFFFFFFF ##1 pos_r == 32'h0);
    c_abs_err: cover property (err_cnt_r == 3'h1 && tick);
    c_operational: cover property (pat == enc_led_pkg::PAT_OPERATIONAL);
endmodule

// ===== quad_decoder.sv
// Quadrature edge decoder: one step pulse per A/B edge with direction
`timescale 1ns/10ps
module quad_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Encoder channels
    input wire logic chan_a,
    input wire logic chan_b,
    // Decoded edge
    output logic step,
    output logic up
);
    logic a_r;
    logic b_r;
    wire moved = (a_r ^ chan_a) ^ (b_r ^ chan_b);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            a_r <= 1'b0;
            b_r <= 1'b0;
        end else begin
            a_r <= chan_a;
            b_r <= chan_b;
        end
    end

    // Double transitions are illegal and dropped
    assign step = moved;
    assign up = a_r ^ chan_b;
endmodule

// ===== tb_enc_position_led.sv
// Self-checking bench for the encoder position and module indicator block
`timescale 1ns/10ps
module tb_enc_position_led;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic abs_fitted = 1'b0;
    logic abs_error = 1'b0;
    logic capture_in = 1'b0;
    logic move_active = 1'b0;
    logic init_done = 1'b1;
    logic link_up = 1'b1;
    logic drive_ok = 1'b1;
    logic net_ok = 1'b1;
    logic net_fl = 1'b0;
    logic comm_fail = 1'b0;
    logic setting_changed = 1'b0;
    logic flash_write_fail = 1'b0;
    logic overtemp = 1'b0;
    logic [31:0] rdata, capture_value;
    logic capture_valid, red, green, irq, chan_a, chan_b, abs_valid;
    logic [20:0] abs_turns;
    logic [10:0] abs_angle;
    int fails = 0;
    int n_checks = 0;
    int n_red = 0;
    int n_grn = 0;
    logic [31:0] seed = 32'h773E;
    logic [31:0] rd_q[$];
    logic [31:0] cap_q[$];
    logic rd_prev = 1'b0;
    logic red_d = 1'b0;
    logic grn_d = 1'b0;
    logic [1:0] res_tab [3] = '{enc_led_pkg::RES_4096, enc_led_pkg::RES_2048,
        enc_led_pkg::RES_1024};

    enc_position_led #(.FLASH_CYCLES(4)) dut_u (.clk(clk), .reset_n(reset_n),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .abs_fitted(abs_fitted), .chan_a(chan_a), .chan_b(chan_b),
        .abs_valid(abs_valid), .abs_turns(abs_turns), .abs_angle(abs_angle),
        .abs_error(abs_error), .capture_in(capture_in), .move_active(move_active),
        .init_done(init_done), .link_up(link_up), .drive_ok(drive_ok),
        .net_ok(net_ok), .network_indicator_flashing(net_fl),
        .comm_fail(comm_fail), .setting_changed(setting_changed),
        .flash_write_fail(flash_write_fail), .overtemp(overtemp),
        .capture_value(capture_value), .capture_valid(capture_valid),
        .module_indicator_red(red), .module_indicator_green(green), .irq(irq));
    enc_partner enc_u (.clk(clk), .reset_n(reset_n), .chan_a(chan_a),
        .chan_b(chan_b), .abs_valid(abs_valid), .abs_turns(abs_turns),
        .abs_angle(abs_angle));

    initial begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    // Expected read data is queued; the monitor compares it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_reset();
        reset_n <= 1'b0;
        wt(5);
        reset_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic steps(input int n, input bit up);
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            enc_u.step(up, 1 + seed[1:0]);
        end
        wt(2);
    endtask
    task automatic cap_pulse();
        capture_in <= 1'b1;
        wt(3);
        capture_in <= 1'b0;
        wt(3);
    endtask
    ////////////////////////////////////////////////////////////////
    // Sampled mid-cycle so every registered output has settled
    always @(negedge clk) begin
        if (rd_prev)
            check(rdata, rd_q.pop_front());
        rd_prev = rd_en;
        if (capture_valid === 1'b1)
            check(capture_value, cap_q.size() ? cap_q.pop_front() : ~capture_value);
        if (red && !red_d)
            n_red++;
        if (green && !grn_d)
            n_grn++;
        red_d = red;
        grn_d = green;
    end
    initial begin
        wt(20000);
        fails++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        do_reset();
        rd(enc_led_pkg::OFF_CONTROL, 32'h12);
        rd(enc_led_pkg::OFF_POSITION, 32'h0);
        rd(8'h1C, 32'h0);
        wr(enc_led_pkg::OFF_POSITION, 32'h55);
        rd(enc_led_pkg::OFF_POSITION, 32'h0);
        steps(1, 1'b0);
        rd(enc_led_pkg::OFF_POSITION, 32'hFFFF_FFFF);
        steps(3, 1'b1);
        rd(enc_led_pkg::OFF_POSITION, 32'h2);
        // Groups of eight edges keep the divider phase aligned
        foreach (res_tab[i]) begin
            do_reset();
            wr(enc_led_pkg::OFF_CONTROL, {27'h0, 3'h5, res_tab[i]});
            steps(8, 1'b1);
            rd(enc_led_pkg::OFF_POSITION, 32'h8 >> i);
        end
        cap_q.push_back(32'h2);
        cap_q.push_back(32'h2);
        cap_pulse();
        rd(enc_led_pkg::OFF_STATUS, 32'h1);
        wr(enc_led_pkg::OFF_IRQ_MASK, 32'h1);
        rd(enc_led_pkg::OFF_IRQ_MASK, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(enc_led_pkg::OFF_STATUS, 32'h1);
        wt(2);
        check({31'h0, irq}, 32'h0);
        wr(enc_led_pkg::OFF_CONTROL, 32'h10);
        cap_pulse();
        wr(enc_led_pkg::OFF_CONTROL, 32'h18);
        cap_pulse();
        move_active <= 1'b1;
        cap_q.push_back(32'h2);
        cap_pulse();
        check(cap_q.size(), 32'h0);
        abs_fitted <= 1'b1;
        seed = xs(seed);
        v = seed;
        enc_u.set_abs(v[31:11], v[10:0]);
        do_reset();
        rd(enc_led_pkg::OFF_POSITION, v);
        steps(4, 1'b1);
        rd(enc_led_pkg::OFF_POSITION, v);
        wr(enc_led_pkg::OFF_CONTROL, 32'h10);
        seed = xs(seed);
        v = seed;
        enc_u.set_abs(v[31:11], v[10:0]);
        wt(2);
        rd(enc_led_pkg::OFF_POSITION, v);
        abs_fitted <= 1'b0;
        init_done <= 1'b0;
        do_reset();
        rd(enc_led_pkg::OFF_LED_STATE, 32'h15);
        n_grn = 0;
        wt(40);
        check({31'h0, n_grn >= 3}, 32'h1);
        init_done <= 1'b1;
        link_up <= 1'b0;
        wt(3);
        rd(enc_led_pkg::OFF_LED_STATE, 32'h16);
        link_up <= 1'b1;
        wt(3);
        rd(enc_led_pkg::OFF_LED_STATE, 32'h17);
        check({30'h0, red, green}, 32'h1);
        drive_ok <= 1'b0;
        wt(3);
        rd(enc_led_pkg::OFF_LED_STATE, 32'h10);
        drive_ok <= 1'b1;
        net_ok <= 1'b0;
        wt(3);
        check({30'h0, red, green}, 32'h0);
        net_ok <= 1'b1;
        wt(3);
        net_fl <= 1'b1;
        setting_changed <= 1'b1;
        wt(1);
        setting_changed <= 1'b0;
        net_fl <= 1'b0;
        wt(3);
        rd(enc_led_pkg::OFF_LED_STATE, 32'h13);
        n_red = 0;
        wt(40);
        check({31'h0, n_red >= 3}, 32'h1);
        comm_fail <= 1'b1;
        wt(1);
        comm_fail <= 1'b0;
        wt(3);
        rd(enc_led_pkg::OFF_LED_STATE, 32'h12);
        check({31'h0, red ^ green}, 32'h1);
        overtemp <= 1'b1;
        wt(1);
        overtemp <= 1'b0;
        wt(3);
        rd(enc_led_pkg::OFF_LED_STATE, 32'h11);
        check({30'h0, red, green}, 32'h2);
        do_reset();
        flash_write_fail <= 1'b1;
        wt(1);
        flash_write_fail <= 1'b0;
        wt(3);
        rd(enc_led_pkg::OFF_LED_STATE, 32'h13);
        rd(enc_led_pkg::OFF_STATUS, 32'h2);
        abs_fitted <= 1'b1;
        abs_error <= 1'b1;
        init_done <= 1'b0;
        do_reset();
        n_red = 0;
        rd(enc_led_pkg::OFF_LED_STATE, 32'h14);
        wt(50);
        check(n_red, 32'h3);
        rd(enc_led_pkg::OFF_STATUS, 32'h4);
        close_out();
    end
endmodule
